// file: pimsm_top.sv
// phy interrupt enable, special control/status and indirect access top
// Operation
// - interrupt enable register at index 30; bits 15:10 and 0 read zero
// - enable bit 0 masks its source, 1 enables; all reset to 0
// - bits 9, 8, 7 gate link up, wake on lan, energy detected
// - bits 6, 5, 4 gate autoneg done, remote fault, link down
// - bits 3, 2, 1 gate partner ack, parallel fault, page received
// - each enable bit pairs with the flag bit in the same position
// - special control/status register at index 31; bits 15:13 reserved
// - bit 12 reads autoneg done, zero after reset
// - bits 11:5 reset to 0000010b; host writes that pattern, ignores reads
// - bits 4:2 report speed and duplex with codes 001,010,101,110
// - indirect registers reached only through control and address/data registers
// - only indirect devices 3, 7 and 30 answer
// - indirect contents follow the clause 45 register layout
// - pcs decodes 0,1,5,6,20,22
// - pcs decodes wake 32784-86, masks 32801-08, address 32865-67
// - autoneg device decodes 5,6,60,61
// - flags latch on enabled events; reading the flag register clears them
`timescale 1ns/1ns
`include "pimsm_consts.svh"
module pimsm_top
  import pimsm_pkg::*;
(
  // clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RSTN,
  // management register port
  input  wire logic [4:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic [15:0]      O_RDATA,
  // phy status, single-cycle events and levels
  input  wire logic        I_LINK_UP,
  input  wire logic        I_WAKE_ON_LAN,
  input  wire logic        I_ENERGY_DETECTED,
  input  wire logic        I_AUTONEG_DONE_EVT,
  input  wire logic        I_REMOTE_FAULT,
  input  wire logic        I_LINK_DOWN,
  input  wire logic        I_PARTNER_ACK,
  input  wire logic        I_PARALLEL_FAULT,
  input  wire logic        I_PAGE_RECEIVED,
  input  wire logic        I_AUTONEG_DONE,
  input  wire logic [2:0]  I_SPEED_DUPLEX,
  input  wire logic [15:0] I_EEE_WAKE_ERRORS,
  input  wire logic [15:0] I_PARTNER_EEE_ADV,
  // interrupt
  output logic             O_IRQ
);
  // -------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // two flops so the release is clean against the clock
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // -------------------------------------------------------------
  // request decode
  // -------------------------------------------------------------
  pimsm_req_t    req;
  pimsm_events_t evt;
  logic          sel_flags;
  logic          sel_enable;
  logic          sel_special;
  logic          sel_iacc_ctrl;
  logic          sel_iacc_data;
  logic          flags_read;

  assign req           = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};
  assign sel_flags     = (req.addr == `PIMSM_IDX_FLAGS);
  assign sel_enable    = (req.addr == `PIMSM_IDX_ENABLE);
  assign sel_special   = (req.addr == `PIMSM_IDX_SPECIAL);
  assign sel_iacc_ctrl = (req.addr == `PIMSM_IDX_IACC_CTRL);
  assign sel_iacc_data = (req.addr == `PIMSM_IDX_IACC_DATA);
  assign flags_read    = req.rd && sel_flags;

  // event bits line up with the enable register positions 9..1
  assign evt = '{link_up: I_LINK_UP, wake_on_lan: I_WAKE_ON_LAN,
                 energy_detected: I_ENERGY_DETECTED, autoneg_done: I_AUTONEG_DONE_EVT,
                 remote_fault: I_REMOTE_FAULT, link_down: I_LINK_DOWN,
                 partner_ack: I_PARTNER_ACK, parallel_detect_fault: I_PARALLEL_FAULT,
                 page_received: I_PAGE_RECEIVED};

  // -------------------------------------------------------------
  // interrupt enable and source flags
  // -------------------------------------------------------------
  logic [15:0] phy_interrupt_enable;
  logic [15:0] phy_interrupt_flags;
  logic [15:0] event_vec;
  logic [15:0] next_flags;

  assign event_vec = {6'h00, evt, 1'b0};

  // a flag only latches when its enable bit is set; a new event beats the read clear
  assign next_flags = ((flags_read ? 16'h0000 : phy_interrupt_flags)
                      | (event_vec & phy_interrupt_enable)) & `PIMSM_ENABLE_MASK;

  // enable register: only bits 9..1 are stored, the rest read zero
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      phy_interrupt_enable <= 16'h0000;
    else if (req.wr && sel_enable)
      phy_interrupt_enable <= req.wdata & `PIMSM_ENABLE_MASK;
  end

  // source flags
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      phy_interrupt_flags <= 16'h0000;
    else
      phy_interrupt_flags <= next_flags;
  end

  // level output; only enabled flags can pull it
  assign O_IRQ = |(phy_interrupt_flags & phy_interrupt_enable);

  // -------------------------------------------------------------
  // special control/status
  // -------------------------------------------------------------
  logic [6:0]  special_fixed;
  logic        autoneg_done;
  logic [2:0]  speed_duplex;
  logic [15:0] phy_special_control_status;

  // the fixed field is stored as written and reads back in bits 11:5
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      special_fixed <= `PIMSM_FIXED_PATTERN;
    else if (req.wr && sel_special)
      special_fixed <= req.wdata[11:5];
  end

  // status sampled once a cycle so reads see a stable value
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      autoneg_done <= 1'b0;
      speed_duplex <= 3'h0;
    end
    else
    begin
      autoneg_done <= I_AUTONEG_DONE;
      speed_duplex <= I_SPEED_DUPLEX;
    end
  end

  assign phy_special_control_status = {3'h0, autoneg_done, special_fixed, speed_duplex, 2'h0};

  // -------------------------------------------------------------
  // indirect access control and address/data
  // -------------------------------------------------------------
  logic [1:0]  indirect_function;
  logic [4:0]  indirect_device_select;
  logic [15:0] indirect_index;
  logic [15:0] indirect_control;
  logic [15:0] indirect_rdata;
  logic        indirect_data_wr;
  logic        indirect_addr_wr;

  // data function routes the address/data port to the selected register
  assign indirect_data_wr = req.wr && sel_iacc_data && (indirect_function == `PIMSM_FUNC_DATA);
  assign indirect_addr_wr = req.wr && sel_iacc_data && (indirect_function == `PIMSM_FUNC_ADDR);
  assign indirect_control = {indirect_function, 9'h000, indirect_device_select};

  // control holds function in bits 15:14 and device in 4:0
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      indirect_function      <= `PIMSM_FUNC_ADDR;
      indirect_device_select <= 5'h00;
    end
    else if (req.wr && sel_iacc_ctrl)
    begin
      indirect_function      <= req.wdata[15:14];
      indirect_device_select <= req.wdata[4:0];
    end
  end

  // index latch
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      indirect_index <= 16'h0000;
    else if (indirect_addr_wr)
      indirect_index <= req.wdata;
  end

  pimsm_indirect u_indirect
  (
    .i_clk             (I_SYS_CLK),
    .i_rst_n           (rst_n),
    .i_dev             (indirect_device_select),
    .i_index           (indirect_index),
    .i_wr              (indirect_data_wr),
    .i_wdata           (req.wdata),
    .i_eee_wake_errors (I_EEE_WAKE_ERRORS),
    .i_partner_eee_adv (I_PARTNER_EEE_ADV),
    .o_rdata           (indirect_rdata),
    .o_hit             ()
  );

  // -------------------------------------------------------------
  // read mux
  // -------------------------------------------------------------
  logic [15:0] read_value;
  logic [15:0] iacc_data_view;

  // address function returns the index; data function the selected register
  assign iacc_data_view = (indirect_function == `PIMSM_FUNC_DATA) ? indirect_rdata : indirect_index;

  // unmapped indices read zero
  assign read_value = sel_enable    ? phy_interrupt_enable :
                      sel_flags     ? phy_interrupt_flags :
                      sel_special   ? phy_special_control_status :
                      sel_iacc_ctrl ? indirect_control :
                      sel_iacc_data ? iacc_data_view : 16'h0000;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      O_RDATA <= 16'h0000;
    else
      O_RDATA <= req.rd ? read_value : 16'h0000;
  end
endmodule

// file: pimsm_consts.svh
// constants for the phy interrupt mask, special status and indirect register block
`ifndef PIMSM_CONSTS_SVH
`define PIMSM_CONSTS_SVH
// register indices on the management port
`define PIMSM_IDX_IACC_CTRL   5'h0d
`define PIMSM_IDX_IACC_DATA   5'h0e
`define PIMSM_IDX_FLAGS       5'h1d
`define PIMSM_IDX_ENABLE      5'h1e
`define PIMSM_IDX_SPECIAL     5'h1f
// field layout
`define PIMSM_ENABLE_MASK     16'h03fe
`define PIMSM_AUTODONE_BIT    12
`define PIMSM_FIXED_PATTERN   7'h02
`define PIMSM_FUNC_ADDR       2'h0
`define PIMSM_FUNC_DATA       2'h1
// indirect device addresses
`define PIMSM_DEV_PCS         5'h03
`define PIMSM_DEV_AN          5'h07
`define PIMSM_DEV_VEND        5'h1e
// pcs indices
`define PIMSM_PCS_CTL1        16'h0000
`define PIMSM_PCS_STAT1       16'h0001
`define PIMSM_DEV_PRES1       16'h0005
`define PIMSM_DEV_PRES2       16'h0006
`define PIMSM_PCS_EEE_CAP     16'h0014
`define PIMSM_PCS_EEE_WERR    16'h0016
`define PIMSM_PCS_WAKE_LO     16'h8010
`define PIMSM_PCS_WAKE_HI     16'h8012
`define PIMSM_PCS_BMASK_LO    16'h8021
`define PIMSM_PCS_BMASK_HI    16'h8028
`define PIMSM_PCS_RXADDR_LO   16'h8061
`define PIMSM_PCS_RXADDR_HI   16'h8063
// auto-negotiation indices
`define PIMSM_AN_EEE_ADV      16'h003c
`define PIMSM_AN_EEE_LPADV    16'h003d
// devices-present contents: auto-negotiation and pcs
`define PIMSM_PRES1_VALUE     16'h0088
// storage slots in the indirect register array
`define PIMSM_SLOT_CTL1       4'h0
`define PIMSM_SLOT_WAKE       4'h1
`define PIMSM_SLOT_BMASK      4'h4
`define PIMSM_SLOT_RXADDR     4'hc
`define PIMSM_SLOT_EEE_ADV    4'hf
`endif

// file: pimsm_pkg.sv
// types for the phy interrupt mask, special status and indirect register block
package pimsm_pkg;
  // one management bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pimsm_req_t;
  // phy status single-cycle events
  typedef struct packed {
    logic       link_up;
    logic       wake_on_lan;
    logic       energy_detected;
    logic       autoneg_done;
    logic       remote_fault;
    logic       link_down;
    logic       partner_ack;
    logic       parallel_detect_fault;
    logic       page_received;
  } pimsm_events_t;
  // indirect decode result
  typedef enum logic [1:0] {
    PIMSM_HIT_NONE  = 2'h0,
    PIMSM_HIT_RO    = 2'h1,
    PIMSM_HIT_RW    = 2'h3
  } pimsm_hit_t;
endpackage

// file: pimsm_indirect.sv
// indirect register space: pcs, auto-negotiation and vendor devices
`timescale 1ns/1ns
`include "pimsm_consts.svh"
module pimsm_indirect
  import pimsm_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // access
  input  wire logic [4:0]  i_dev,
  input  wire logic [15:0] i_index,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_wdata,
  // status inputs
  input  wire logic [15:0] i_eee_wake_errors,
  input  wire logic [15:0] i_partner_eee_adv,
  // result
  output logic [15:0]      o_rdata,
  output pimsm_hit_t       o_hit
);
  logic [15:0] store [16];
  logic [3:0]  slot;
  logic [15:0] ro_value;

  // -------------------------------------------------------------
  // decode: only pcs, auto-negotiation and vendor devices answer
  // -------------------------------------------------------------
  function automatic pimsm_hit_t decode(input logic [4:0] dev, input logic [15:0] idx);
    pimsm_hit_t h;
    h = PIMSM_HIT_NONE;
    if (dev == `PIMSM_DEV_PCS)
    begin
      if (idx == `PIMSM_PCS_CTL1)
        h = PIMSM_HIT_RW;
      else if (idx == `PIMSM_PCS_STAT1 || idx == `PIMSM_DEV_PRES1 || idx == `PIMSM_DEV_PRES2)
        h = PIMSM_HIT_RO;
      else if (idx == `PIMSM_PCS_EEE_CAP || idx == `PIMSM_PCS_EEE_WERR)
        h = PIMSM_HIT_RO;
      else if (idx >= `PIMSM_PCS_WAKE_LO && idx <= `PIMSM_PCS_WAKE_HI)
        h = PIMSM_HIT_RW;
      else if (idx >= `PIMSM_PCS_BMASK_LO && idx <= `PIMSM_PCS_BMASK_HI)
        h = PIMSM_HIT_RW;
      else if (idx >= `PIMSM_PCS_RXADDR_LO && idx <= `PIMSM_PCS_RXADDR_HI)
        h = PIMSM_HIT_RW;
    end
    else if (dev == `PIMSM_DEV_AN)
    begin
      if (idx == `PIMSM_DEV_PRES1 || idx == `PIMSM_DEV_PRES2 || idx == `PIMSM_AN_EEE_LPADV)
        h = PIMSM_HIT_RO;
      else if (idx == `PIMSM_AN_EEE_ADV)
        h = PIMSM_HIT_RW;
    end
    else if (dev == `PIMSM_DEV_VEND)
    begin
      if (idx == `PIMSM_DEV_PRES1 || idx == `PIMSM_DEV_PRES2)
        h = PIMSM_HIT_RO;
    end
    return h;
  endfunction

  assign o_hit = decode(i_dev, i_index);

  // slot of a writable register, offsets from each range base
  assign slot = (i_index == `PIMSM_PCS_CTL1)     ? `PIMSM_SLOT_CTL1 :
                (i_index == `PIMSM_AN_EEE_ADV)   ? `PIMSM_SLOT_EEE_ADV :
                (i_index <= `PIMSM_PCS_WAKE_HI)  ? 4'(`PIMSM_SLOT_WAKE + 4'(i_index - `PIMSM_PCS_WAKE_LO)) :
                (i_index <= `PIMSM_PCS_BMASK_HI) ? 4'(`PIMSM_SLOT_BMASK + 4'(i_index - `PIMSM_PCS_BMASK_LO)) :
                4'(`PIMSM_SLOT_RXADDR + 4'(i_index - `PIMSM_PCS_RXADDR_LO));

  // read-only contents; status bits the model does not track read zero
  assign ro_value = (i_index == `PIMSM_DEV_PRES1)    ? `PIMSM_PRES1_VALUE :
                    (i_index == `PIMSM_PCS_EEE_WERR) ? i_eee_wake_errors :
                    (i_index == `PIMSM_AN_EEE_LPADV) ? i_partner_eee_adv : 16'h0000;

  // read data: unsupported devices and indices read zero
  assign o_rdata = (o_hit == PIMSM_HIT_RW) ? store[slot] :
                   (o_hit == PIMSM_HIT_RO) ? ro_value : 16'h0000;

  // writable storage, cleared at reset
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int k = 0; k < 16; k++)
        store[k] <= 16'h0000;
    end
    else if (i_wr && o_hit == PIMSM_HIT_RW)
      store[slot] <= i_wdata;
  end
endmodule

// file: pimsm_top_sva.sv
// assertion checker for the phy interrupt enable and special status block
`timescale 1ns/1ns
`include "pimsm_consts.svh"
module pimsm_checker
(
  // clock, reset and register port
  input wire logic        I_SYS_CLK,
  input wire logic        I_RSTN,
  input wire logic [4:0]  I_ADDR,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire logic [15:0] O_RDATA,
  // phy status
  input wire logic        I_LINK_UP,
  input wire logic        I_WAKE_ON_LAN,
  input wire logic        I_ENERGY_DETECTED,
  input wire logic        I_AUTONEG_DONE_EVT,
  input wire logic        I_REMOTE_FAULT,
  input wire logic        I_LINK_DOWN,
  input wire logic        I_PARTNER_ACK,
  input wire logic        I_PARALLEL_FAULT,
  input wire logic        I_PAGE_RECEIVED,
  input wire logic        I_AUTONEG_DONE,
  input wire logic [2:0]  I_SPEED_DUPLEX,
  input wire logic        O_IRQ
);
  // -------------------------------------------
  // properties
  // -------------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  logic any_evt;
  // any event pulse; a flag can only appear after one
  assign any_evt = |{I_LINK_UP, I_WAKE_ON_LAN, I_ENERGY_DETECTED, I_AUTONEG_DONE_EVT, I_REMOTE_FAULT,
                     I_LINK_DOWN, I_PARTNER_ACK, I_PARALLEL_FAULT, I_PAGE_RECEIVED};
  sequence rd_at(logic [4:0] a);
    $past(I_RD) && $past(I_ADDR) == a;
  endsequence
  a_unmapped_zero: assert property ($past(I_RD) && $past(I_ADDR) < 5'h0d |-> O_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_enable_rsvd: assert property (rd_at(`PIMSM_IDX_ENABLE) |-> (O_RDATA & 16'hfc01) == 16'h0000)
    else $error("enable reserved bits set");
  a_special_rsvd: assert property (rd_at(`PIMSM_IDX_SPECIAL) |-> O_RDATA[15:13] == 3'h0 && O_RDATA[1:0] == 2'h0)
    else $error("special reserved bits set");
  a_autodone_bit: assert property ($past(I_RD) && $past(I_ADDR) == `PIMSM_IDX_SPECIAL &&
    $past(I_AUTONEG_DONE, 2) == $past(I_AUTONEG_DONE) |-> O_RDATA[12] == $past(I_AUTONEG_DONE))
    else $error("autodone bit wrong");
  a_speed_field: assert property ($past(I_RD) && $past(I_ADDR) == `PIMSM_IDX_SPECIAL &&
    $past(I_SPEED_DUPLEX, 2) == $past(I_SPEED_DUPLEX) |-> O_RDATA[4:2] == $past(I_SPEED_DUPLEX))
    else $error("speed field wrong");
  a_irq_cause: assert property ($rose(O_IRQ) |-> $past(any_evt) || $past(I_WR))
    else $error("interrupt without cause");
  a_flags_clear: assert property (I_RD && I_ADDR == `PIMSM_IDX_FLAGS && !any_evt |=> !O_IRQ)
    else $error("flag read did not clear");
  a_irq_hold: assert property (O_IRQ && !I_WR && !(I_RD && I_ADDR == `PIMSM_IDX_FLAGS) |=> O_IRQ)
    else $error("interrupt dropped");
  c_special_read: cover property (rd_at(`PIMSM_IDX_SPECIAL));
  c_irq_rise: cover property ($rose(O_IRQ));
  c_indirect_data: cover property (rd_at(`PIMSM_IDX_IACC_DATA) ##0 O_RDATA != 16'h0000);
endmodule
bind pimsm_top pimsm_checker u_pimsm_checker (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_LINK_UP(I_LINK_UP), .I_WAKE_ON_LAN(I_WAKE_ON_LAN),
  .I_ENERGY_DETECTED(I_ENERGY_DETECTED), .I_AUTONEG_DONE_EVT(I_AUTONEG_DONE_EVT),
  .I_REMOTE_FAULT(I_REMOTE_FAULT), .I_LINK_DOWN(I_LINK_DOWN), .I_PARTNER_ACK(I_PARTNER_ACK),
  .I_PARALLEL_FAULT(I_PARALLEL_FAULT), .I_PAGE_RECEIVED(I_PAGE_RECEIVED), .I_AUTONEG_DONE(I_AUTONEG_DONE),
  .I_SPEED_DUPLEX(I_SPEED_DUPLEX), .O_IRQ(O_IRQ));

// file: pimsm_host_model.sv
// management host model driving the register port
`timescale 1ns/1ns
`include "pimsm_consts.svh"
module pimsm_host_model
(
  // clock
  input  wire logic        i_clk,
  // register port
  output logic [4:0]       o_addr,
  output logic [15:0]      o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  initial
  begin
    o_addr = 5'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // one-cycle strobes; an edge passes between two so a strobe is never set twice in a step
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    {o_wr, o_addr, o_wdata} <= {1'b1, a, d};
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge i_clk);
    {o_rd, o_addr} <= {1'b1, a};
    @(posedge i_clk);
    o_rd <= 1'b0;
  endtask
  // indirect space is only reached through the control and address/data pair
  task automatic ind(input logic [4:0] dev, input logic [15:0] idx);
    wr(`PIMSM_IDX_IACC_CTRL, {`PIMSM_FUNC_ADDR, 9'h000, dev});
    wr(`PIMSM_IDX_IACC_DATA, idx);
    wr(`PIMSM_IDX_IACC_CTRL, {`PIMSM_FUNC_DATA, 9'h000, dev});
  endtask
endmodule

// file: tb_pimsm_top.sv
// self-checking bench for the phy interrupt enable and special status block
`timescale 1ns/1ns
`include "pimsm_consts.svh"
`define PIMSM_CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_pimsm_top
  import pimsm_pkg::*;
;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  wire  [4:0]    addr;
  wire  [15:0]   wdata;
  wire           wr;
  wire           rd;
  logic [15:0]   rdata;
  logic          irq;
  logic          an_done = 1'b0;
  logic [2:0]    speed = 3'h1;
  logic [15:0]   wake_err = 16'h0000;
  logic [15:0]   lp_adv = 16'h0000;
  pimsm_events_t ev = '0;
  logic [15:0]   exp_q[$];
  logic [15:0]   exp_rd;
  logic          rd_seen = 1'b0;
  logic [15:0]   seed = 16'h0028;
  logic [15:0]   en;
  logic [15:0]   flags;
  logic [8:0]    e;
  logic [2:0]    codes[4] = '{3'h1, 3'h2, 3'h5, 3'h6};
  int            miscompares = 0;
  int            samples_checked = 0;
  int            cycles = 0;
  always #25 clk = ~clk;
  pimsm_host_model u_pimsm_host_model (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  pimsm_top u_pimsm_top (.I_SYS_CLK(clk), .I_RSTN(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_LINK_UP(ev.link_up), .I_WAKE_ON_LAN(ev.wake_on_lan),
    .I_ENERGY_DETECTED(ev.energy_detected), .I_AUTONEG_DONE_EVT(ev.autoneg_done),
    .I_REMOTE_FAULT(ev.remote_fault), .I_LINK_DOWN(ev.link_down), .I_PARTNER_ACK(ev.partner_ack),
    .I_PARALLEL_FAULT(ev.parallel_detect_fault), .I_PAGE_RECEIVED(ev.page_received),
    .I_AUTONEG_DONE(an_done), .I_SPEED_DUPLEX(speed), .I_EEE_WAKE_ERRORS(wake_err),
    .I_PARTNER_EEE_ADV(lp_adv), .O_IRQ(irq));
  // -------------------------------------------
  // helpers
  // -------------------------------------------
  function automatic logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  // expected special register image; bits 11:5 hold the fixed pattern
  function automatic logic [15:0] spc(input logic ad, input logic [2:0] sd);
    return {3'h0, ad, `PIMSM_FIXED_PATTERN, sd, 2'h0};
  endfunction
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] x);
    exp_q.push_back(x);
    u_pimsm_host_model.rd(a);
  endtask
  task automatic ind_chk(input logic [4:0] dev, input logic [15:0] idx, input logic [15:0] x);
    u_pimsm_host_model.ind(dev, idx);
    rd_chk(`PIMSM_IDX_IACC_DATA, x);
  endtask
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe, so compare at that negedge
  always @(posedge clk) rd_seen <= rd;
  // pop once into a variable: the check macro names its expected value twice
  always @(negedge clk)
    if (rd_seen)
    begin
      exp_rd = exp_q.pop_front();
      `PIMSM_CHK(rdata, exp_rd)
    end
  // a hang is cut short well past the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  // -------------------------------------------
  // main sequence
  // -------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(`PIMSM_IDX_ENABLE, 16'h0000);
    rd_chk(`PIMSM_IDX_SPECIAL, spc(1'b0, 3'h1));
    u_pimsm_host_model.wr(`PIMSM_IDX_ENABLE, 16'hffff);
    rd_chk(`PIMSM_IDX_ENABLE, `PIMSM_ENABLE_MASK);
    rd_chk(5'h03, 16'h0000);
    foreach (codes[i])
    begin
      speed <= codes[i];
      an_done <= codes[i][2];
      u_pimsm_host_model.wr(`PIMSM_IDX_SPECIAL, 16'h0040);
      rd_chk(`PIMSM_IDX_SPECIAL, spc(codes[i][2], codes[i]));
    end
    // one source at a time first, then random enables against random events
    for (int i = 0; i < 18; i++)
    begin
      en = (i < 9) ? 16'h0002 << i : xs() & `PIMSM_ENABLE_MASK;
      e = (i < 9) ? 9'h001 << i : 9'(xs());
      flags = {6'h00, e, 1'b0} & en;
      u_pimsm_host_model.wr(`PIMSM_IDX_ENABLE, en);
      @(posedge clk);
      ev <= pimsm_events_t'(e);
      @(posedge clk);
      ev <= '0;
      @(negedge clk);
      `PIMSM_CHK(irq, |flags)
      rd_chk(`PIMSM_IDX_FLAGS, flags);
      @(negedge clk);
      `PIMSM_CHK(irq, 1'b0)
    end
    u_pimsm_host_model.wr(`PIMSM_IDX_FLAGS, 16'hffff);
    rd_chk(`PIMSM_IDX_FLAGS, 16'h0000);
    wake_err <= xs();
    lp_adv <= xs();
    ind_chk(`PIMSM_DEV_PCS, `PIMSM_DEV_PRES1, `PIMSM_PRES1_VALUE);
    ind_chk(`PIMSM_DEV_AN, `PIMSM_DEV_PRES1, `PIMSM_PRES1_VALUE);
    ind_chk(`PIMSM_DEV_VEND, `PIMSM_DEV_PRES1, `PIMSM_PRES1_VALUE);
    ind_chk(5'h01, `PIMSM_DEV_PRES1, 16'h0000);
    ind_chk(`PIMSM_DEV_PCS, `PIMSM_PCS_EEE_WERR, wake_err);
    ind_chk(`PIMSM_DEV_AN, `PIMSM_AN_EEE_LPADV, lp_adv);
    ind_chk(`PIMSM_DEV_AN, `PIMSM_PCS_EEE_WERR, 16'h0000);
    u_pimsm_host_model.ind(`PIMSM_DEV_PCS, `PIMSM_PCS_RXADDR_LO);
    u_pimsm_host_model.wr(`PIMSM_IDX_IACC_DATA, 16'ha5c3);
    rd_chk(`PIMSM_IDX_IACC_DATA, 16'ha5c3);
    u_pimsm_host_model.wr(`PIMSM_IDX_IACC_CTRL, {`PIMSM_FUNC_ADDR, 9'h000, `PIMSM_DEV_PCS});
    u_pimsm_host_model.wr(`PIMSM_IDX_IACC_DATA, `PIMSM_PCS_BMASK_HI);
    rd_chk(`PIMSM_IDX_IACC_DATA, `PIMSM_PCS_BMASK_HI);
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule
